/* dv/eps_prog_model.sv */
// Programmer model: mode pins, address, code byte and pulse train.
// Assumes the bench supplies core_clk and calls its tasks.
`timescale 1ns/1ps
module eps_prog_model #(
    parameter int SU_CYC = 4
) (
    // Clock
    input  wire logic   core_clk,
    // Pins toward the device
    output logic        rst_pin,
    output logic        latch_program_strobe,
    output logic        external_access_level,
    output logic        prog_supply_present,
    output logic [3:0]  mode_sel,
    output logic [14:0] prog_addr,
    output logic [7:0]  port0_in
);
    initial begin
        {rst_pin, latch_program_strobe, external_access_level, prog_supply_present} = 4'b0110;
        {mode_sel, prog_addr, port0_in} = 27'h0;
    end
    // Static session levels, held before any pulse
    task automatic setup(input logic [3:0] m, input logic [14:0] a, input logic [7:0] d);
        @(posedge core_clk);
        rst_pin <= 1'b1;
        mode_sel <= m;
        prog_addr <= a;
        port0_in <= d;
        repeat (SU_CYC) @(posedge core_clk);
    endtask
    // Leave the session so the next setup gives a reset rising edge
    task automatic drop_rst;
        @(posedge core_clk);
        rst_pin <= 1'b0;
        repeat (SU_CYC) @(posedge core_clk);
    endtask
    // Pulse train bracketed by the programming supply
    task automatic burn(input int n, input int lo);
        external_access_level <= 1'b0;
        prog_supply_present <= 1'b1;
        repeat (SU_CYC) @(posedge core_clk);
        repeat (n) begin
            latch_program_strobe <= 1'b0;
            repeat (lo) @(posedge core_clk);
            latch_program_strobe <= 1'b1;
            repeat (SU_CYC) @(posedge core_clk);
        end
        prog_supply_present <= 1'b0;
        external_access_level <= 1'b1;
        @(posedge core_clk);
    endtask
endmodule // eps_prog_model

/* dv/eps_sequencer_chk.sv */
// Port checker for eps_sequencer, bound into every instance.
// Assumes one clock domain and the async reset arst_n.
`timescale 1ns/1ps
module eps_chk (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        arst_n,
    // Register bus
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Pins and protections
    input wire logic        port2_bit7,
    input wire logic        port0_oe,
    input wire logic        table_read_block,
    input wire logic        ext_exec_disable,
    input wire logic        ram_access_disable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Bus handshake and unmapped space
    property p_wait_first; $rose(avs_read | avs_write) |-> avs_waitrequest; endproperty
    property p_one_wait; (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    property p_idle; !(avs_read | avs_write) |-> !avs_waitrequest; endproperty
    property p_unmapped; avs_read && !avs_waitrequest && !(avs_address inside {4'h0, 4'h4, 4'h8})
        |-> avs_readdata == 32'h0; endproperty
    property p_rd_hold; !avs_read |=> $stable(avs_readdata); endproperty
    // Protection levels and port float
    property p_lock3; ext_exec_disable == ram_access_disable; endproperty
    property p_lock_nest; ext_exec_disable |-> table_read_block; endproperty
    property p_float; port2_bit7 [*5] |-> !port0_oe; endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait state on new request");
    a_one_wait: assert property (p_one_wait) else $error("wait state longer than one cycle");
    a_idle: assert property (p_idle) else $error("waitrequest without request");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");
    a_lock3: assert property (p_lock3) else $error("level three outputs differ");
    a_lock_nest: assert property (p_lock_nest) else $error("level three without level one");
    a_float: assert property (p_float) else $error("port0 driven with enable high");
    c_read: cover property (avs_read && !avs_waitrequest);
    c_lock: cover property ($rose(table_read_block));
    c_float: cover property ($fell(port0_oe));
endmodule // eps_chk
bind eps_sequencer eps_chk chk_u (.*);

/* dv/test_eps_sequencer.sv */
// Self-checking bench for eps_sequencer with the programmer model.
// Assumes pulse limits shrunk to 8..12 cycles and pull-ups on port0.
`timescale 1ns/1ps
`include "eps_regs.svh"
`define CHK(nm, ex, ac) begin cmp_count++; if ((ac) !== (ex)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, ac); end end
module test_eps_sequencer;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, rst_pin, latch_program_strobe, external_access_level;
    logic        prog_supply_present, port0_oe, table_read_block, acc_latched;
    logic        ext_exec_disable, ram_access_disable;
    logic [3:0]  mode_sel;
    logic [14:0] prog_addr, a;
    logic [7:0]  port0_in, port0_out, d, t;
    logic [63:0] exp_q[$];
    int          num_errors = 0;
    int          cmp_count = 0;
    wire         program_store_strobe_n = 1'b0;
    wire         port2_bit7 = mode_sel[3];
    wire         port2_bit6 = mode_sel[2];
    wire         port3_bit7 = mode_sel[1];
    wire         port3_bit6 = mode_sel[0];
    wire  [7:0]  port0 = port0_oe ? port0_out : 8'hff;
    eps_sequencer #(.PULSE_MIN_CYC(8), .PULSE_MAX_CYC(12)) dut_u (.*);
    eps_prog_model prog_u (.*);
    always #4 core_clk = ~core_clk;
    // Watcher: each accepted read takes the oldest note, mask on top
    always @(posedge core_clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            `CHK("readdata", exp_q[0][31:0], avs_readdata & exp_q[0][63:32])
            void'(exp_q.pop_front());
        end
    end
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One bus access held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] v,
                       input logic [63:0] e);
        int n;
        @(posedge core_clk);
        avs_address <= ad;
        avs_writedata <= v;
        avs_read <= !w;
        avs_write <= w;
        if (!w) exp_q.push_back(e);
        n = 0;
        do begin @(posedge core_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n == 50) begin num_errors++; report_and_stop(); end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        #1;
    endtask
    // Present a read-side mode and address, then sample port0
    task automatic look(input logic [3:0] m, input logic [14:0] ad, input logic o,
                        input logic [7:0] e);
        prog_u.setup(m, ad, 8'h00);
        repeat (4) @(posedge core_clk);
        `CHK("port0", {o, e}, {port0_oe, port0})
    endtask
    initial begin
        repeat (100000) @(posedge core_clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        void'($urandom(27));
        a = 15'($urandom);
        d = 8'($urandom);
        t = 8'($urandom);
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        bus(0, `EPS_REG_STATUS, 0, {32'hffffffff, 32'h0});
        bus(0, `EPS_REG_CTRL, 0, {32'hffffffff, 32'h2});
        bus(0, 4'hc, 0, {32'hffffffff, 32'h0});
        bus(1, `EPS_REG_CTRL, 32'h3, 0);
        repeat (32800) @(posedge core_clk);
        bus(0, `EPS_REG_STATUS, 0, {32'hffffffff, 32'h0});
        look(4'b0011, a, 1'b1, 8'hff);
        $display("bus and erase done");
        prog_u.setup(4'b1011, a, d);
        prog_u.burn(25, 10);
        look(4'b0011, a, 1'b1, d);
        prog_u.setup(4'b1010, {9'h0, a[5:0]}, t);
        prog_u.burn(25, 10);
        look(4'b0011, a, 1'b1, ~(d ^ t));
        look(4'b0000, `EPS_ID_ADDR0, 1'b1, `EPS_ID_BYTE0);
        look(4'b0000, `EPS_ID_ADDR1, 1'b1, `EPS_ID_BYTE1);
        prog_u.setup(4'b1011, a ^ 15'h1, 8'h00);
        prog_u.burn(24, 10);
        prog_u.burn(1, 5);
        look(4'b0011, a ^ 15'h1, 1'b1, 8'hff);
        bus(0, `EPS_REG_STATUS, 0, {32'h80, 32'h80});
        $display("program and verify done");
        prog_u.setup(4'b1111, a, 8'h00);
        prog_u.burn(25, 10);
        `CHK("table_read_block", 1'b1, table_read_block)
        prog_u.drop_rst();
        prog_u.setup(4'b1011, a, 8'h00);
        prog_u.burn(25, 10);
        `CHK("acc_latched", 1'b1, acc_latched)
        look(4'b0011, a, 1'b1, ~(d ^ t));
        bus(0, `EPS_REG_STATUS, 0, {32'h4f, 32'h49});
        prog_u.setup(4'b1100, a, 8'h00);
        prog_u.burn(25, 10);
        look(4'b0011, a, 1'b0, 8'hff);
        `CHK("ext_exec_disable", 1'b0, ext_exec_disable)
        prog_u.setup(4'b0101, a, 8'h00);
        prog_u.burn(25, 10);
        `CHK("ext_exec_disable", 1'b1, ext_exec_disable)
        `CHK("ram_access_disable", 1'b1, ram_access_disable)
        $display("lock levels done");
        report_and_stop();
    end
endmodule // test_eps_sequencer

/* rtl/eps_pkg.sv */
// Types shared by the EPROM program/verify sequencer.
// Assumes nothing of its surroundings.
package eps_pkg;

    // ------------------------------------------------------------------------
    // Mode selected by the static control pins
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        EPS_MODE_NONE,
        EPS_MODE_ID_READ,
        EPS_MODE_PGM_CODE,
        EPS_MODE_VERIFY,
        EPS_MODE_PGM_TABLE,
        EPS_MODE_PGM_LK1,
        EPS_MODE_PGM_LK2,
        EPS_MODE_PGM_LK3
    } eps_mode_t;

    // ------------------------------------------------------------------------
    // Pulse sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        EPS_ST_IDLE,
        EPS_ST_LOW,
        EPS_ST_HIGH,
        EPS_ST_WRITE,
        EPS_ST_ERASE
    } eps_state_t;

endpackage

/* rtl/eps_regs.svh */
// Register map, field positions and timing constants of the EPROM sequencer.
// Assumes a 125 MHz core clock and byte addresses on the Avalon-MM slave.
`ifndef EPS_REGS_SVH
`define EPS_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define EPS_REG_CTRL        4'h0
`define EPS_REG_STATUS      4'h4
`define EPS_REG_PULSES      4'h8
`define EPS_AW              4

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define EPS_CTRL_ERASE      0
`define EPS_CTRL_PGM_EN     1
`define EPS_ST_LOCK_LO      0
`define EPS_ST_LOCK_HI      2
`define EPS_ST_TABLE        3
`define EPS_ST_BUSY         4
`define EPS_ST_UNDEF        5
`define EPS_ST_REFUSED      6
`define EPS_ST_BADPULSE     7
`define EPS_ST_MODE_LO      8
`define EPS_ST_MODE_HI      10

// ----------------------------------------------------------------------------
// Reset values and array constants
// ----------------------------------------------------------------------------
`define EPS_CTRL_RST        2'h2
`define EPS_ERASED          8'hff
`define EPS_CODE_AW         15
`define EPS_CODE_LAST       15'h7fff
`define EPS_ENC_AW          6
`define EPS_ID_ADDR0        15'h0030
`define EPS_ID_ADDR1        15'h0031
// Id byte values are arbitrary, not a maker's codes
`define EPS_ID_BYTE0        8'h5a
`define EPS_ID_BYTE1        8'ha5

// ----------------------------------------------------------------------------
// Programming pulse timing
// ----------------------------------------------------------------------------
`define EPS_PULSES_NEEDED   5'h19
`define EPS_CLK_MHZ         125
`define EPS_PULSE_MIN_NS    90000
`define EPS_PULSE_MAX_NS    110000
`define EPS_PW_W            16

`endif

/* rtl/eps_sequencer.sv */
// EPROM program/verify sequencer: pin mode decode, programming pulse
// counting, code/table/lock storage, verify readout and Avalon-MM registers.
// Assumes pins come from an external programmer and are asynchronous.
//
// Summary of operation
// - Verify data valid quickly; float after enable
// - No locks: only encryption applies to verify
// - Lock one: block table reads, latch access
// - Locks one, two: also disable verify readout
// - All locks: no external execution, no RAM
// - Other lock combinations flagged as unsupported
// - Erase sets code ones, clears table, locks
// - Encrypted verify is XNOR; table never read
// - Id read returns bytes at 030H, 031H
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "eps_regs.svh"

module eps_sequencer #(
    parameter int PULSE_MIN_CYC = (`EPS_PULSE_MIN_NS * `EPS_CLK_MHZ + 999) / 1000,
    parameter int PULSE_MAX_CYC = (`EPS_PULSE_MAX_NS * `EPS_CLK_MHZ) / 1000
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Programming control pins
    input  wire logic        rst_pin,
    input  wire logic        program_store_strobe_n,
    input  wire logic        latch_program_strobe,
    input  wire logic        external_access_level,
    input  wire logic        prog_supply_present,
    input  wire logic        port2_bit7,
    input  wire logic        port2_bit6,
    input  wire logic        port3_bit7,
    input  wire logic        port3_bit6,
    // Address and data ports
    input  wire logic [14:0] prog_addr,
    input  wire logic [7:0]  port0_in,
    output logic      [7:0]  port0_out,
    output logic             port0_oe,
    // Protection outputs to the core
    output logic             table_read_block,
    output logic             acc_latched,
    output logic             ext_exec_disable,
    output logic             ram_access_disable
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [31:0] pins_s;
    eps_sync #(.W(32)) u_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .d_in     ({rst_pin, program_store_strobe_n, latch_program_strobe,
                    external_access_level, prog_supply_present, port2_bit7,
                    port2_bit6, port3_bit7, port3_bit6, prog_addr, port0_in}),
        .q_out    (pins_s)
    );
    logic        rst_s, pst_s, strobe_s, acc_s, sup_s;
    logic [3:0]  sel_s;
    logic [14:0] addr_s;
    logic [7:0]  din_s;
    assign {rst_s, pst_s, strobe_s, acc_s, sup_s} = pins_s[31:27];
    assign sel_s  = pins_s[26:23];
    assign addr_s = pins_s[22:8];
    assign din_s  = pins_s[7:0];

    // ------------------------------------------------------------------------
    // Mode decode from static pin levels
    // ------------------------------------------------------------------------
    eps_pkg::eps_mode_t mode;
    always_comb begin
        mode = eps_pkg::EPS_MODE_NONE;
        if (rst_s && !pst_s) begin
            unique case (sel_s)
                4'h0:    mode = strobe_s && acc_s ? eps_pkg::EPS_MODE_ID_READ
                                                  : eps_pkg::EPS_MODE_NONE;
                4'hb:    mode = eps_pkg::EPS_MODE_PGM_CODE;
                4'h3:    mode = strobe_s && acc_s ? eps_pkg::EPS_MODE_VERIFY
                                                  : eps_pkg::EPS_MODE_NONE;
                4'ha:    mode = eps_pkg::EPS_MODE_PGM_TABLE;
                4'hf:    mode = eps_pkg::EPS_MODE_PGM_LK1;
                4'hc:    mode = eps_pkg::EPS_MODE_PGM_LK2;
                4'h5:    mode = eps_pkg::EPS_MODE_PGM_LK3;
                default: mode = eps_pkg::EPS_MODE_NONE;
            endcase
        end
    end
    logic pgm_mode;
    assign pgm_mode = (mode == eps_pkg::EPS_MODE_PGM_CODE)  ||
                      (mode == eps_pkg::EPS_MODE_PGM_TABLE) ||
                      (mode == eps_pkg::EPS_MODE_PGM_LK1)   ||
                      (mode == eps_pkg::EPS_MODE_PGM_LK2)   ||
                      (mode == eps_pkg::EPS_MODE_PGM_LK3);

    // ------------------------------------------------------------------------
    // Storage arrays
    // ------------------------------------------------------------------------
    logic [7:0] code_mem [0:(1 << `EPS_CODE_AW) - 1];
    logic [7:0] enc_mem  [0:(1 << `EPS_ENC_AW) - 1];

    // ------------------------------------------------------------------------
    // Sequencer, lock and register state
    // ------------------------------------------------------------------------
    eps_pkg::eps_state_t     state_ff, nxt_state;
    logic [`EPS_PW_W-1:0]    width_ff, nxt_width;
    logic [4:0]              pulses_ff, nxt_pulses;
    logic [14:0]             wr_addr_ff, nxt_wr_addr;
    logic [7:0]              wr_data_ff, nxt_wr_data;
    eps_pkg::eps_mode_t      wr_mode_ff, nxt_wr_mode;
    logic [2:0]              lock_ff, nxt_lock;
    logic                    table_ff, nxt_table;
    logic                    refused_ff, nxt_refused;
    logic                    badpulse_ff, nxt_badpulse;
    logic [1:0]              ctrl_ff, nxt_ctrl;
    logic                    acc_lat_ff, nxt_acc_lat;
    logic                    rst_prev_ff, nxt_rst_prev;
    logic                    ack_ff, nxt_ack;
    logic [31:0]             rdata_ff, nxt_rdata;
    logic                    mem_we;
    logic                    bus_req, bus_wr_done, erase_go;

    assign bus_req     = avs_read || avs_write;
    assign bus_wr_done = avs_write && ack_ff;
    assign erase_go    = bus_wr_done && (avs_address == `EPS_REG_CTRL) &&
                         avs_writedata[`EPS_CTRL_ERASE];
    assign mem_we      = (state_ff == eps_pkg::EPS_ST_WRITE) ||
                         (state_ff == eps_pkg::EPS_ST_ERASE);

    // Next-state logic of the pulse sequencer and locks
    always_comb begin
        nxt_state    = state_ff;
        nxt_width    = width_ff;
        nxt_pulses   = pulses_ff;
        nxt_wr_addr  = wr_addr_ff;
        nxt_wr_data  = wr_data_ff;
        nxt_wr_mode  = wr_mode_ff;
        nxt_lock     = lock_ff;
        nxt_table    = table_ff;
        nxt_refused  = refused_ff;
        nxt_badpulse = badpulse_ff;
        unique case (state_ff)
            eps_pkg::EPS_ST_IDLE, eps_pkg::EPS_ST_HIGH: begin
                if (erase_go) begin
                    nxt_state   = eps_pkg::EPS_ST_ERASE;
                    nxt_wr_addr = '0;
                end else if (!pgm_mode || !sup_s || !ctrl_ff[`EPS_CTRL_PGM_EN]) begin
                    nxt_state  = eps_pkg::EPS_ST_IDLE;
                    nxt_pulses = '0;
                end else if (!strobe_s) begin
                    nxt_state   = eps_pkg::EPS_ST_LOW;
                    nxt_width   = `EPS_PW_W'(1);  // This first low cycle counts
                    nxt_wr_addr = addr_s;
                    nxt_wr_data = din_s;
                    nxt_wr_mode = mode;
                end
            end
            eps_pkg::EPS_ST_LOW: begin
                if (!sup_s || mode != wr_mode_ff) begin
                    nxt_state  = eps_pkg::EPS_ST_IDLE;
                    nxt_pulses = '0;
                end else if (strobe_s) begin
                    if (width_ff < `EPS_PW_W'(PULSE_MIN_CYC) ||
                        width_ff > `EPS_PW_W'(PULSE_MAX_CYC)) begin
                        nxt_badpulse = 1'b1;
                        nxt_state    = eps_pkg::EPS_ST_HIGH;
                    end else if (pulses_ff == `EPS_PULSES_NEEDED - 5'h1) begin
                        nxt_state  = eps_pkg::EPS_ST_WRITE;
                        nxt_pulses = '0;
                    end else begin
                        nxt_pulses = pulses_ff + 5'h1;
                        nxt_state  = eps_pkg::EPS_ST_HIGH;
                    end
                end else if (width_ff != {`EPS_PW_W{1'b1}}) begin
                    nxt_width = width_ff + `EPS_PW_W'(1);
                end
            end
            eps_pkg::EPS_ST_WRITE: begin
                nxt_state = eps_pkg::EPS_ST_HIGH;
                unique case (wr_mode_ff)
                    eps_pkg::EPS_MODE_PGM_CODE:  nxt_refused = lock_ff[0];
                    eps_pkg::EPS_MODE_PGM_TABLE: begin
                        nxt_refused = lock_ff[0] || (wr_addr_ff[14:6] != '0);
                        nxt_table   = table_ff || !nxt_refused;
                    end
                    eps_pkg::EPS_MODE_PGM_LK1:   nxt_lock[0] = 1'b1;
                    eps_pkg::EPS_MODE_PGM_LK2:   nxt_lock[1] = 1'b1;
                    eps_pkg::EPS_MODE_PGM_LK3:   nxt_lock[2] = 1'b1;
                    default:                     nxt_refused = 1'b1;
                endcase
            end
            eps_pkg::EPS_ST_ERASE: begin
                nxt_wr_addr = wr_addr_ff + 15'h1;
                if (wr_addr_ff == `EPS_CODE_LAST) begin
                    nxt_state    = eps_pkg::EPS_ST_IDLE;
                    nxt_lock     = '0;
                    nxt_table    = 1'b0;
                    nxt_refused  = 1'b0;
                    nxt_badpulse = 1'b0;
                    nxt_pulses   = '0;
                end
            end
            default: nxt_state = eps_pkg::EPS_ST_IDLE;
        endcase
    end

    // Sequencer and lock registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff    <= eps_pkg::EPS_ST_IDLE;
            width_ff    <= '0;
            pulses_ff   <= '0;
            wr_addr_ff  <= '0;
            wr_data_ff  <= '0;
            wr_mode_ff  <= eps_pkg::EPS_MODE_NONE;
            lock_ff     <= '0;
            table_ff    <= 1'b0;
            refused_ff  <= 1'b0;
            badpulse_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            width_ff    <= nxt_width;
            pulses_ff   <= nxt_pulses;
            wr_addr_ff  <= nxt_wr_addr;
            wr_data_ff  <= nxt_wr_data;
            wr_mode_ff  <= nxt_wr_mode;
            lock_ff     <= nxt_lock;
            table_ff    <= nxt_table;
            refused_ff  <= nxt_refused;
            badpulse_ff <= nxt_badpulse;
        end
    end

    // Array writes: code programming only clears bits, table programming overwrites the byte, erase sets all to ones
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            if (state_ff == eps_pkg::EPS_ST_ERASE) begin
                code_mem[wr_addr_ff] <= `EPS_ERASED;
                enc_mem[wr_addr_ff[`EPS_ENC_AW-1:0]] <= `EPS_ERASED;
            end else if (wr_mode_ff == eps_pkg::EPS_MODE_PGM_CODE && !lock_ff[0]) begin
                code_mem[wr_addr_ff] <= code_mem[wr_addr_ff] & wr_data_ff;
            end else if (wr_mode_ff == eps_pkg::EPS_MODE_PGM_TABLE && !lock_ff[0] &&
                         wr_addr_ff[14:6] == '0) begin
                enc_mem[wr_addr_ff[`EPS_ENC_AW-1:0]] <= wr_data_ff;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Verify and id readout on port zero
    // ------------------------------------------------------------------------
    logic [7:0] dout_ff, nxt_dout;
    logic       oe_ff, nxt_oe;
    logic [7:0] raw_byte;
    assign raw_byte = code_mem[addr_s];

    // Readout data and drive enable
    always_comb begin
        nxt_dout = dout_ff;
        nxt_oe   = 1'b0;
        if (state_ff == eps_pkg::EPS_ST_IDLE && mode == eps_pkg::EPS_MODE_ID_READ) begin
            nxt_oe   = (addr_s == `EPS_ID_ADDR0) || (addr_s == `EPS_ID_ADDR1);
            nxt_dout = (addr_s == `EPS_ID_ADDR0) ? `EPS_ID_BYTE0 : `EPS_ID_BYTE1;
        end else if (state_ff == eps_pkg::EPS_ST_IDLE &&
                     mode == eps_pkg::EPS_MODE_VERIFY && !lock_ff[1]) begin
            nxt_oe   = 1'b1;
            nxt_dout = table_ff ? ~(raw_byte ^ enc_mem[addr_s[`EPS_ENC_AW-1:0]])
                                : raw_byte;
        end
    end

    // Readout registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dout_ff <= '0;
            oe_ff   <= 1'b0;
        end else begin
            dout_ff <= nxt_dout;
            oe_ff   <= nxt_oe;
        end
    end
    assign port0_out = dout_ff;
    assign port0_oe  = oe_ff;

    // ------------------------------------------------------------------------
    // Protection levels and access latch
    // ------------------------------------------------------------------------
    logic lock_undef;
    assign lock_undef = (lock_ff != 3'h0) && (lock_ff != 3'h1) &&
                        (lock_ff != 3'h3) && (lock_ff != 3'h7);
    assign table_read_block   = lock_ff[0] || lock_undef;
    assign ext_exec_disable   = (lock_ff == 3'h7) || lock_undef;
    assign ram_access_disable = (lock_ff == 3'h7) || lock_undef;
    assign acc_latched        = acc_lat_ff;

    // ------------------------------------------------------------------------
    // Avalon-MM slave: one wait state on every access
    // ------------------------------------------------------------------------
    assign avs_waitrequest = bus_req && !ack_ff;
    assign avs_readdata    = rdata_ff;

    // Bus, control and access latch next values
    always_comb begin
        nxt_ack      = bus_req && !ack_ff;
        nxt_rdata    = rdata_ff;
        nxt_ctrl     = ctrl_ff;
        nxt_rst_prev = rst_s;
        nxt_acc_lat  = acc_lat_ff;
        if (rst_s && !rst_prev_ff && lock_ff[0]) begin
            nxt_acc_lat = acc_s;
        end
        if (avs_read && !ack_ff) begin
            nxt_rdata = '0;
            unique case (avs_address)
                `EPS_REG_CTRL:   nxt_rdata[1:0] = ctrl_ff;
                `EPS_REG_STATUS: begin
                    nxt_rdata[`EPS_ST_LOCK_HI:`EPS_ST_LOCK_LO] = lock_ff;
                    nxt_rdata[`EPS_ST_TABLE]    = table_ff;
                    nxt_rdata[`EPS_ST_BUSY]     = state_ff == eps_pkg::EPS_ST_ERASE;
                    nxt_rdata[`EPS_ST_UNDEF]    = lock_undef;
                    nxt_rdata[`EPS_ST_REFUSED]  = refused_ff;
                    nxt_rdata[`EPS_ST_BADPULSE] = badpulse_ff;
                    nxt_rdata[`EPS_ST_MODE_HI:`EPS_ST_MODE_LO] = mode;
                end
                `EPS_REG_PULSES: nxt_rdata[4:0] = pulses_ff;
                default:         nxt_rdata = '0;
            endcase
        end
        if (bus_wr_done && avs_address == `EPS_REG_CTRL) begin
            nxt_ctrl[`EPS_CTRL_PGM_EN] = avs_writedata[`EPS_CTRL_PGM_EN];
        end
    end

    // Bus and control registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_ff      <= 1'b0;
            rdata_ff    <= '0;
            ctrl_ff     <= `EPS_CTRL_RST;
            rst_prev_ff <= 1'b0;
            acc_lat_ff  <= 1'b0;
        end else begin
            ack_ff      <= nxt_ack;
            rdata_ff    <= nxt_rdata;
            ctrl_ff     <= nxt_ctrl;
            rst_prev_ff <= nxt_rst_prev;
            acc_lat_ff  <= nxt_acc_lat;
        end
    end

endmodule // eps_sequencer

/* rtl/eps_sync.sv */
// Two-flop synchroniser for a bundle of pin levels.
// Assumes each bit is a slow static level; bits are not coherent as a word.
`timescale 1ns/1ps

module eps_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    // Levels
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // First stage feeds only the second
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
        end
    end

    assign q_out = sync_ff;

endmodule // eps_sync
